/* File: pwc_channel_config.sv */
/*
  pwc_channel_config: apb register file and control of a four
  channel 8-bit pulse width modulator: enables, start levels,
  clock picks, alignment, pair joining and the clock dividers.
  assumes: a single apb master on mclk; counters, period and duty
  logic sit outside and consume the per channel outputs here.
*/
// Decided for this implementation: the APB register port.
// Notes on behaviour
// - enable opens output now, waveform at next tick
// - first waveform cycle after enable may be irregular
// - joined pair runs from low-order channel enable
// - joined high-order enable ignored, its line off
// - all enables clear stops the prescaler counter
// - start level one: high, low at duty
// - start level zero: low, high at duty
// - polarity, clock, prescale writes act immediately
// - channels 0,1: pick 0 clock a, 1 scaled
// - channels 2,3: pick 0 clock b, 1 scaled
// - bits 2..0 divide bus clock for a
// - bits 6..4 divide bus clock for b
// - alignment bit one centre, zero left aligned
// - per channel bits sit at channel number
// - joined pair uses output three's or output one's settings
// - scaled clock divides by twice scale, zero=256
`timescale 1ns/1ps
module pwc_channel_config #(
  parameter int NCHAN = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [3:0]       chanOutEnable,
  output logic [3:0]       chanRun,
  output logic [3:0]       chanTick,
  output logic [3:0]       chanStartHigh,
  output logic [3:0]       chanCenter,
  output logic             joinUpperPair,
  output logic             joinLowerPair,
  output logic             clockTickA,
  output logic             clockTickB,
  output logic             scaledClockFirst,
  output logic             scaledClockSecond
);
  // elaboration check: the pair wiring is fixed at four channels
  if (NCHAN != 4) begin : g_chk
    $error("pwc_channel_config: NCHAN must be 4");
  end

  // software visible state
  logic [3:0] enable_reg;     // chan_enable_bit per channel
  logic [3:0] enable_next;
  logic [3:0] polarity_reg;   // start_level_bit per channel
  logic [3:0] polarity_next;
  logic [3:0] clkSel_reg;     // chan_clock_pick per channel
  logic [3:0] clkSel_next;
  logic [7:0] prescale_reg;   // both divider selects
  logic [7:0] prescale_next;
  logic [3:0] align_reg;      // center_align_bit per channel
  logic [3:0] align_next;
  logic [1:0] join_reg;       // {upper, lower} pair joined
  logic [1:0] join_next;
  logic [7:0] scaleA_reg;     // scale value for clock a
  logic [7:0] scaleA_next;
  logic [7:0] scaleB_reg;     // scale value for clock b
  logic [7:0] scaleB_next;

  // bus answer state
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // per channel outputs
  logic [3:0] outEn_reg;      // output line enabled
  logic [3:0] outEn_next;
  logic [3:0] run_reg;        // waveform live, synced to tick
  logic [3:0] run_next;
  logic [3:0] tick_reg;       // selected channel clock pulse
  logic [3:0] tick_next;
  logic [3:0] startHigh_reg;
  logic [3:0] startHigh_next;
  logic [3:0] center_reg;
  logic [3:0] center_next;
  logic [1:0] joinOut_reg;
  logic [1:0] joinOut_next;
  logic       tickA_reg;
  logic       tickA_next;
  logic       tickB_reg;
  logic       tickB_next;
  logic       sTickA_reg;
  logic       sTickA_next;
  logic       sTickB_reg;
  logic       sTickB_next;

  // internal nets
  logic       preRun;         // prescaler allowed to count
  logic       rawTickA;       // prescaler pulses
  logic       rawTickB;
  logic       rawScaledA;     // scaler pulses
  logic       rawScaledB;
  logic       wrScaleA;       // write strobes to scale values
  logic       wrScaleB;
  logic       wrEn;           // write completes this edge
  logic       setup;          // setup phase of a transfer
  logic [7:0] widx;           // word index of the access
  logic [3:0] effEn;          // enable after pair masking

  // word index: byte address over four
  function automatic logic [7:0] wordIdx(input logic [11:0] a);
    return a[9:2];
  endfunction

  // address decode, used for both read and write
  function automatic logic isMapped(input logic [7:0] i);
    unique case (i)
      pwc_pkg::IDX_ENABLE, pwc_pkg::IDX_POLARITY,
      pwc_pkg::IDX_CLKSEL, pwc_pkg::IDX_PRESCALE,
      pwc_pkg::IDX_ALIGN,  pwc_pkg::IDX_CONTROL,
      pwc_pkg::IDX_SCALE_A, pwc_pkg::IDX_SCALE_B,
      pwc_pkg::IDX_STATUS: return 1'b1;
      default:             return 1'b0;
    endcase
  endfunction

  assign widx  = wordIdx(paddr);
  assign setup = psel && !penable;
  // pready was raised in the setup cycle, so access ends now
  assign wrEn  = psel && penable && pready_reg && pwrite
                 && isMapped(widx) && (paddr[1:0] == 2'h0);
  assign wrScaleA = wrEn && (widx == pwc_pkg::IDX_SCALE_A);
  assign wrScaleB = wrEn && (widx == pwc_pkg::IDX_SCALE_B);

  // counter runs while any raw enable is set
  assign preRun = |enable_reg;

  // divider chain for clocks a and b
  pwc_prescaler #(
    .PRE_W (pwc_pkg::PRE_W)
  ) u_pre (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run   (preRun),
    .selA  (prescale_reg[pwc_pkg::DIV_FIRST_LSB +: pwc_pkg::DIV_W]),
    .selB  (prescale_reg[pwc_pkg::DIV_SECOND_LSB +: pwc_pkg::DIV_W]),
    .tickA (rawTickA),
    .tickB (rawTickB)
  );

  // scaled clock from clock a
  pwc_scaler #(
    .SCALE_W (pwc_pkg::SCALE_W)
  ) u_scaleA (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .srcTick    (rawTickA),
    .scale      (scaleA_reg),
    .reload     (wrScaleA),
    .scaledTick (rawScaledA)
  );

  // scaled clock from clock b
  pwc_scaler #(
    .SCALE_W (pwc_pkg::SCALE_W)
  ) u_scaleB (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .srcTick    (rawTickB),
    .scale      (scaleB_reg),
    .reload     (wrScaleB),
    .scaledTick (rawScaledB)
  );

  // register writes; any moment, effect without waiting
  always_comb begin
    enable_next   = enable_reg;
    polarity_next = polarity_reg;
    clkSel_next   = clkSel_reg;
    prescale_next = prescale_reg;
    align_next    = align_reg;
    join_next     = join_reg;
    scaleA_next   = scaleA_reg;
    scaleB_next   = scaleB_reg;
    if (wrEn) begin
      unique case (widx)
        pwc_pkg::IDX_ENABLE:   enable_next   = pwdata[3:0];
        pwc_pkg::IDX_POLARITY: polarity_next = pwdata[3:0];
        pwc_pkg::IDX_CLKSEL:   clkSel_next   = pwdata[3:0];
        // bits 7 and 3 are reserved and stay zero
        pwc_pkg::IDX_PRESCALE: prescale_next = pwdata[7:0] & 8'h77;
        // alignment is taken as written; keeping it still is
        // the software's task while the channel is enabled
        pwc_pkg::IDX_ALIGN:    align_next    = pwdata[3:0];
        pwc_pkg::IDX_CONTROL: begin
          join_next = {pwdata[pwc_pkg::JOIN_UPPER_BIT],
                       pwdata[pwc_pkg::JOIN_LOWER_BIT]};
        end
        pwc_pkg::IDX_SCALE_A:  scaleA_next   = pwdata[7:0];
        pwc_pkg::IDX_SCALE_B:  scaleB_next   = pwdata[7:0];
        default: begin
          // status is read only, writes dropped
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enable_reg   <= pwc_pkg::RST_CHAN;
      polarity_reg <= pwc_pkg::RST_CHAN;
      clkSel_reg   <= pwc_pkg::RST_CHAN;
      prescale_reg <= pwc_pkg::RST_PRESC;
      align_reg    <= pwc_pkg::RST_CHAN;
      join_reg     <= pwc_pkg::RST_JOIN;
      scaleA_reg   <= pwc_pkg::RST_SCALE;
      scaleB_reg   <= pwc_pkg::RST_SCALE;
    end else begin
      enable_reg   <= enable_next;
      polarity_reg <= polarity_next;
      clkSel_reg   <= clkSel_next;
      prescale_reg <= prescale_next;
      align_reg    <= align_next;
      join_reg     <= join_next;
      scaleA_reg   <= scaleA_next;
      scaleB_reg   <= scaleB_next;
    end
  end

  // apb answer: one wait-free access, data prepared in setup
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup && (!isMapped(widx) || paddr[1:0] != 2'h0);
    prdata_next  = setup ? 32'h0000_0000 : prdata_reg;
    if (setup && !pwrite && paddr[1:0] == 2'h0) begin
      unique case (widx)
        pwc_pkg::IDX_ENABLE:   prdata_next = {28'h0, enable_reg};
        pwc_pkg::IDX_POLARITY: prdata_next = {28'h0, polarity_reg};
        pwc_pkg::IDX_CLKSEL:   prdata_next = {28'h0, clkSel_reg};
        pwc_pkg::IDX_PRESCALE: prdata_next = {24'h0, prescale_reg};
        pwc_pkg::IDX_ALIGN:    prdata_next = {28'h0, align_reg};
        pwc_pkg::IDX_CONTROL: begin
          prdata_next = 32'h0000_0000;
          prdata_next[pwc_pkg::JOIN_UPPER_BIT] = join_reg[1];
          prdata_next[pwc_pkg::JOIN_LOWER_BIT] = join_reg[0];
        end
        pwc_pkg::IDX_SCALE_A:  prdata_next = {24'h0, scaleA_reg};
        pwc_pkg::IDX_SCALE_B:  prdata_next = {24'h0, scaleB_reg};
        pwc_pkg::IDX_STATUS: begin
          prdata_next = 32'h0000_0000;
          prdata_next[pwc_pkg::STAT_PRE_BIT] = preRun;
          prdata_next[pwc_pkg::STAT_RUN_LSB +: 4] = run_reg;
        end
        default: prdata_next = 32'h0000_0000; // unmapped reads 0
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // pair masking: a joined high-order channel never runs
  always_comb begin
    effEn    = enable_reg;
    effEn[2] = enable_reg[2] && !join_reg[1];
    effEn[0] = enable_reg[0] && !join_reg[0];
  end

  // per channel clock pick, enable sync and mode bits
  always_comb begin
    tickA_next  = rawTickA;
    tickB_next  = rawTickB;
    sTickA_next = rawScaledA;
    sTickB_next = rawScaledB;
    for (int i = 0; i < 4; i++) begin
      if (i < 2) begin
        tick_next[i] = clkSel_reg[i] ? rawScaledA : rawTickA;
      end else begin
        tick_next[i] = clkSel_reg[i] ? rawScaledB : rawTickB;
      end
      // line opens at once; waveform waits for the next tick,
      // so the first cycle may be short
      outEn_next[i] = effEn[i];
      run_next[i]   = effEn[i] && (run_reg[i] || tick_next[i]);
    end
    // joined pair: low-order pin 3 / pin 1 carry the settings
    startHigh_next = polarity_reg;
    center_next    = align_reg;
    joinOut_next   = join_reg;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outEn_reg     <= pwc_pkg::RST_CHAN;
      run_reg       <= pwc_pkg::RST_CHAN;
      tick_reg      <= pwc_pkg::RST_CHAN;
      startHigh_reg <= pwc_pkg::RST_CHAN;
      center_reg    <= pwc_pkg::RST_CHAN;
      joinOut_reg   <= pwc_pkg::RST_JOIN;
      tickA_reg     <= 1'b0;
      tickB_reg     <= 1'b0;
      sTickA_reg    <= 1'b0;
      sTickB_reg    <= 1'b0;
    end else begin
      outEn_reg     <= outEn_next;
      run_reg       <= run_next;
      tick_reg      <= tick_next;
      startHigh_reg <= startHigh_next;
      center_reg    <= center_next;
      joinOut_reg   <= joinOut_next;
      tickA_reg     <= tickA_next;
      tickB_reg     <= tickB_next;
      sTickA_reg    <= sTickA_next;
      sTickB_reg    <= sTickB_next;
    end
  end

  // outputs straight from flops
  assign pready            = pready_reg;
  assign prdata            = prdata_reg;
  assign pslverr           = pslverr_reg;
  assign chanOutEnable     = outEn_reg;
  assign chanRun           = run_reg;
  assign chanTick          = tick_reg;
  assign chanStartHigh     = startHigh_reg;
  assign chanCenter        = center_reg;
  assign joinUpperPair     = joinOut_reg[1];
  assign joinLowerPair     = joinOut_reg[0];
  assign clockTickA        = tickA_reg;
  assign clockTickB        = tickB_reg;
  assign scaledClockFirst  = sTickA_reg;
  assign scaledClockSecond = sTickB_reg;
endmodule

/* File: pwc_channel_config_props.sv */
/*
  pwc_channel_config_props: port level checker for the channel
  configuration block.
  assumes: bound to pwc_channel_config, sees only its ports.
*/
`timescale 1ns/1ps
module pwc_channel_config_props #(
  parameter int NCHAN = 4
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [3:0]  chanOutEnable,
  input wire logic [3:0]  chanRun,
  input wire logic [3:0]  chanTick,
  input wire logic [3:0]  chanStartHigh,
  input wire logic [3:0]  chanCenter,
  input wire logic        joinUpperPair,
  input wire logic        joinLowerPair,
  input wire logic        clockTickA,
  input wire logic        clockTickB,
  input wire logic        scaledClockFirst,
  input wire logic        scaledClockSecond
);
  // one domain, reset silences every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // slave answers in the access cycle, never elsewhere
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_in_access: assert property
    (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("ready outside access cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // masked lines are checked once the join bit has been high two cycles
  chk_join_upper_off: assert property
    (joinUpperPair && $past(joinUpperPair) |-> !chanOutEnable[2])
    else $error("line 2 live while upper pair joined");
  chk_join_lower_off: assert property
    (joinLowerPair && $past(joinLowerPair) |-> !chanOutEnable[0])
    else $error("line 0 live while lower pair joined");
  chk_run_needs_enable: assert property
    ((chanRun & ~chanOutEnable) == 4'h0)
    else $error("waveform live on a disabled line");
  chk_run_on_tick: assert property
    ((chanRun & ~$past(chanRun) & ~chanTick) == 4'h0)
    else $error("waveform started off its clock tick");
  // ignores joined cases, where a raw enable may hide behind the mask
  chk_prescale_idle: assert property
    ((chanOutEnable == 4'h0 && !joinUpperPair && !joinLowerPair)[*3]
     |-> !clockTickA && !clockTickB)
    else $error("prescaler ticking with all channels off");
  chk_tick_src_a: assert property (|chanTick[1:0] |->
    clockTickA || scaledClockFirst || $past(clockTickA || scaledClockFirst))
    else $error("low channel tick without clock a source");
  chk_tick_src_b: assert property (|chanTick[3:2] |->
    clockTickB || scaledClockSecond || $past(clockTickB || scaledClockSecond))
    else $error("high channel tick without clock b source");
endmodule

bind pwc_channel_config pwc_channel_config_props #(.NCHAN(NCHAN)) u_props (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .chanOutEnable(chanOutEnable),
  .chanRun(chanRun), .chanTick(chanTick), .chanStartHigh(chanStartHigh),
  .chanCenter(chanCenter), .joinUpperPair(joinUpperPair),
  .joinLowerPair(joinLowerPair), .clockTickA(clockTickA),
  .clockTickB(clockTickB), .scaledClockFirst(scaledClockFirst),
  .scaledClockSecond(scaledClockSecond));

/* File: pwc_channel_config_tb.sv */
/*
  pwc_channel_config_tb: self-checking bench for the channel
  configuration block, driving apb and timing the tick outputs.
  assumes: design and checker compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
module pwc_channel_config_tb;
  localparam int LIMIT = 20000; // run needs about 3400 cycles
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  chanOutEnable, chanRun, chanTick, chanStartHigh, chanCenter;
  logic        joinUpperPair, joinLowerPair, clockTickA, clockTickB;
  logic        scaledClockFirst, scaledClockSecond;
  int          errors = 0, checks_done = 0, cycles = 0;

  pwc_channel_config u_pwc_channel_config (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chanOutEnable(chanOutEnable),
    .chanRun(chanRun), .chanTick(chanTick), .chanStartHigh(chanStartHigh),
    .chanCenter(chanCenter), .joinUpperPair(joinUpperPair),
    .joinLowerPair(joinLowerPair), .clockTickA(clockTickA),
    .clockTickB(clockTickB), .scaledClockFirst(scaledClockFirst),
    .scaledClockSecond(scaledClockSecond));

  // 4 ns clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard: a stuck wait ends here as a mismatch
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("[FAIL] %0t run timed out", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one apb transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 16), 32'h1, "apb answer");
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "read error");
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = clockTickA;
      1: pick = clockTickB;
      2: pick = chanTick[0];
      4: pick = scaledClockFirst;
      5: pick = scaledClockSecond;
      default: pick = chanTick[3];
    endcase
  endfunction

  // cycles between 2nd and 3rd pulse; the first may be irregular
  task automatic gap(input int w, output int g);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!pick(w) && n < 1100);
    end
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (!pick(w) && g < 1100);
  endtask

  task automatic testReset();
    logic [11:0] adr [8] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                             12'h010, 12'h014, 12'h020, 12'h024};
    chk(32'({chanOutEnable, chanRun, chanStartHigh}), 32'h0, "reset out");
    foreach (adr[i]) rd(adr[i], 32'h0, 1'b0);
  endtask

  // access kinds, reserved bits and unmapped places
  task automatic testRegs();
    wr(12'h004, 32'hFF);
    rd(12'h004, 32'h0F, 1'b0);
    chk(32'(chanStartHigh), 32'hF, "start level");
    wr(12'h004, 32'h05);
    rd(12'h004, 32'h05, 1'b0);
    chk(32'(chanStartHigh), 32'h5, "start level");
    wr(12'h010, 32'hFF);
    rd(12'h010, 32'h0F, 1'b0);
    chk(32'(chanCenter), 32'hF, "center");
    wr(12'h010, 32'h00);
    rd(12'h010, 32'h00, 1'b0);
    chk(32'(chanCenter), 32'h0, "left");
    wr(12'h008, 32'hFF);
    rd(12'h008, 32'h0F, 1'b0);
    wr(12'h00C, 32'hFF);
    rd(12'h00C, 32'h77, 1'b0);
    rd(12'h018, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    wr(12'h008, 32'h00);
  endtask

  task automatic testRate();
    int g;
    wr(12'h000, 32'h1);
    for (int s = 0; s < 8; s++) begin
      wr(12'h00C, 32'(s));
      gap(0, g);
      chk(32'(g), 32'(1 << s), "clock a period");
      wr(12'h00C, 32'(s << 4));
      gap(1, g);
      chk(32'(g), 32'(1 << s), "clock b period");
    end
  endtask

  task automatic testEnable();
    wr(12'h00C, 32'h00);
    wr(12'h000, 32'h8);
    cyc(1);
    chk(32'(chanOutEnable), 32'h8, "line on");
    cyc(4);
    chk(32'(chanRun), 32'h8, "waveform live");
    wr(12'h000, 32'h0);
    cyc(1);
    chk(32'({chanOutEnable, chanRun}), 32'h0, "line off");
  endtask

  task automatic testJoin();
    wr(12'h014, 32'h30);
    rd(12'h014, 32'h30, 1'b0);
    chk(32'({joinUpperPair, joinLowerPair}), 32'h3, "joined");
    wr(12'h000, 32'hF);
    cyc(1);
    chk(32'(chanOutEnable), 32'hA, "joined lines");
    wr(12'h000, 32'h5);
    cyc(1);
    chk(32'(chanOutEnable), 32'h0, "high bytes ignored");
    wr(12'h000, 32'h0);
    wr(12'h014, 32'h00);
  endtask

  task automatic testScaled();
    int g;
    wr(12'h00C, 32'h10);
    wr(12'h008, 32'h9);
    wr(12'h020, 32'h2);
    wr(12'h024, 32'h1);
    wr(12'h000, 32'h9);
    gap(2, g);
    chk(32'(g), 32'h4, "scaled a");
    gap(3, g);
    chk(32'(g), 32'h4, "scaled b");
    gap(4, g);
    chk(32'(g), 32'h4, "scaled a out");
    gap(5, g);
    chk(32'(g), 32'h4, "scaled b out");
    rd(12'h080, 32'h91, 1'b0);
    wr(12'h020, 32'h0);
    gap(2, g);
    chk(32'(g), 32'h200, "scale zero");
    wr(12'h008, 32'h0);
    gap(2, g);
    chk(32'(g), 32'h1, "plain a");
    gap(3, g);
    chk(32'(g), 32'h2, "plain b");
  endtask

  task automatic testIdle();
    int n = 0;
    wr(12'h000, 32'h0);
    cyc(4);
    repeat (40) begin
      @(posedge mclk);
      n += int'(clockTickA) + int'(clockTickB);
    end
    chk(32'(n), 32'h0, "idle ticks");
    rd(12'h080, 32'h0, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    testReset();
    testRegs();
    testRate();
    testEnable();
    testJoin();
    testScaled();
    testIdle();
    summarize();
  end
endmodule

/* File: pwc_pkg.sv */
/*
  pwc_pkg: register map, field layout and reset values of the
  channel configuration block of a four channel modulator.
  assumes: a 32-bit apb slave, each register one aligned word at
  byte address four times its index.
*/
package pwc_pkg;
  // register indices, byte address is index * 4
  localparam logic [7:0] IDX_ENABLE   = 8'h00; // channel_enable
  localparam logic [7:0] IDX_POLARITY = 8'h01; // output_polarity
  localparam logic [7:0] IDX_CLKSEL   = 8'h02; // channel_clock_select
  localparam logic [7:0] IDX_PRESCALE = 8'h03; // prescale_select
  localparam logic [7:0] IDX_ALIGN    = 8'h04; // alignment_select
  localparam logic [7:0] IDX_CONTROL  = 8'h05; // pair joining
  localparam logic [7:0] IDX_SCALE_A  = 8'h08; // scale value, first
  localparam logic [7:0] IDX_SCALE_B  = 8'h09; // scale value, second
  localparam logic [7:0] IDX_STATUS   = 8'h20; // running state, ro

  // field positions
  localparam int DIV_FIRST_LSB  = 0;  // div_sel_first, bits 2..0
  localparam int DIV_SECOND_LSB = 4;  // div_sel_second, bits 6..4
  localparam int DIV_W          = 3;  // width of both selects
  localparam int JOIN_LOWER_BIT = 4;  // join_lower_pair
  localparam int JOIN_UPPER_BIT = 5;  // join_upper_pair
  localparam int STAT_PRE_BIT   = 0;  // prescaler running
  localparam int STAT_RUN_LSB   = 4;  // per channel waveform live

  // reset values
  localparam logic [3:0] RST_CHAN   = 4'h0; // per channel bits
  localparam logic [7:0] RST_PRESC  = 8'h00;
  localparam logic [1:0] RST_JOIN   = 2'h0;
  localparam logic [7:0] RST_SCALE  = 8'h00;

  // counter sizes
  localparam int PRE_W   = 7;  // prescaler reaches divide by 128
  localparam int SCALE_W = 8;  // scale value width
endpackage

/* File: pwc_prescaler.sv */
/*
  pwc_prescaler: free running bus clock counter whose taps give
  one-cycle enable pulses for clock a and clock b.
  assumes: selects may change at any time; a short or long first
  tick after a change is acceptable.
*/
`timescale 1ns/1ps
module pwc_prescaler #(
  parameter int PRE_W = pwc_pkg::PRE_W
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        run,
  input  wire logic [pwc_pkg::DIV_W-1:0]   selA,
  input  wire logic [pwc_pkg::DIV_W-1:0]   selB,
  output logic                             tickA,
  output logic                             tickB
);
  logic [PRE_W-1:0] count_reg;   // shared divider chain
  logic [PRE_W-1:0] count_next;

  if (PRE_W != (1 << pwc_pkg::DIV_W) - 1) begin : g_chk
    $error("pwc_prescaler: PRE_W must be 2**DIV_W - 1");
  end

  // ones in the low sel bits: tap of divide by 2**sel
  function automatic logic [PRE_W-1:0] tapMask(
      input logic [pwc_pkg::DIV_W-1:0] sel);
    logic [PRE_W:0] m;
    m = (PRE_W+1)'(1) << sel;
    return PRE_W'(m - (PRE_W+1)'(1));
  endfunction

  // counter stops at zero while run is low (all enable bits clear), saving power
  always_comb begin
    count_next = run ? count_reg + PRE_W'(1) : '0;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // pulse when all low bits are ones: 2**sel cycles apart
  assign tickA = run && ((count_reg & tapMask(selA)) == tapMask(selA));
  assign tickB = run && ((count_reg & tapMask(selB)) == tapMask(selB));
endmodule

/* File: pwc_scaler.sv */
/*
  pwc_scaler: divides a source tick stream by twice an 8-bit scale
  value; zero counts as 256, giving a division by 512.
  assumes: srcTick is a one-cycle pulse; reload marks a write of
  the scale value and restarts the count.
*/
`timescale 1ns/1ps
module pwc_scaler #(
  parameter int SCALE_W = pwc_pkg::SCALE_W
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               srcTick,
  input  wire logic [SCALE_W-1:0] scale,
  input  wire logic               reload,
  output logic                    scaledTick
);
  localparam int CNT_W = SCALE_W + 2;  // holds 2 * 256 - 1

  logic [CNT_W-1:0] count_reg;   // source ticks seen
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] last;        // last count of a period
  logic             tick_reg;    // registered output pulse
  logic             tick_next;

  if (SCALE_W < 1) begin : g_chk
    $error("pwc_scaler: SCALE_W must be at least 1");
  end

  // period of 2 * scale source ticks, zero read as full scale
  always_comb begin
    last = {(scale == '0), scale, 1'b0} - CNT_W'(1);
    count_next = count_reg;
    tick_next  = 1'b0;
    if (reload) begin
      count_next = '0;   // write restarts the scale count
    end else if (srcTick) begin
      if (count_reg >= last) begin
        count_next = '0;
        tick_next  = 1'b1;
      end else begin
        count_next = count_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign scaledTick = tick_reg;
endmodule
